// *** bench/mcr_top_checker.sv ***
`timescale 1ns/1ps
module mcr_top_checker (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic o_hall_u,
    input wire logic o_rotor_lockup_fault,
    input wire logic o_comm_count_reset,
    input wire logic [15:0] o_commutation_count,
    input wire logic o_gate_dead,
    input wire logic o_gate_boost,
    input wire logic o_speed_filter_enable,
    input wire logic [11:0] o_speed_filter_pole_coeff,
    input wire logic [11:0] o_speed_filter_zero_coeff
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_hall_rise;
        $rose(o_hall_u);
    endsequence
    sequence s_boost_start;
        $rose(o_gate_boost);
    endsequence
    chk_bypass_zero: assert property (!o_speed_filter_enable |->
        o_speed_filter_pole_coeff == 0 && o_speed_filter_zero_coeff == 0) else $error("coefficient leaks in bypass");
    chk_gap_follows: assert property (s_hall_rise |-> ##[0:3] o_gate_dead)
        else $error("no dead gap after Hall rise");
    chk_gap_min: assert property ($rose(o_gate_dead) |-> o_gate_dead[*3])
        else $error("dead gap too short");
    chk_gap_boost_excl: assert property (!(o_gate_dead && o_gate_boost))
        else $error("boost overlaps dead gap");
    chk_boost_after_gap: assert property (s_boost_start |-> $past(o_gate_dead))
        else $error("boost without gap");
    chk_boost_min: assert property (s_boost_start |-> o_gate_boost[*8])
        else $error("boost too short");
    chk_rst_pulse: assert property (o_comm_count_reset |=> !o_comm_count_reset)
        else $error("counter reset not one cycle");
    chk_count_restart: assert property (o_comm_count_reset |=> o_commutation_count <= 16'h0002)
        else $error("counter not restarted");
    chk_lock_clear: assert property (s_hall_rise |-> ##[0:3] !o_rotor_lockup_fault)
        else $error("lockup fault kept after Hall edge");
    chk_count_step: assert property ((o_commutation_count != 16'h0000) &&
        (o_commutation_count != 16'hFFFF) |=> o_comm_count_reset ||
        (o_commutation_count == $past(o_commutation_count) + 16'h0001))
        else $error("commutation count did not advance");
endmodule // mcr_top_checker
bind mcr_top mcr_top_checker u_chk (.i_clk, .i_arst_n, .o_hall_u, .o_rotor_lockup_fault, .o_comm_count_reset,
    .o_commutation_count, .o_gate_dead, .o_gate_boost, .o_speed_filter_enable, .o_speed_filter_pole_coeff,
    .o_speed_filter_zero_coeff);

// *** bench/motor_commutation_loop_config_regs_tb_top.sv ***
`timescale 1ns/1ps
module motor_commutation_loop_config_regs_tb_top;
    import mcr_pkg::*;
    logic i_clk = 0, i_arst_n = 0, cs = 0, sclk = 0, mosi = 0, hall = 0;
    logic miso, oe, oe_seen, hall_o, fault, crst, lead, adv, agn, sine, dead, boost, tick, fen;
    logic [2:0] peak;
    logic [11:0] gain, pole, zero;
    int fails = 0, num_checks = 0, n_rst = 0, n_tick = 0, b, n;
    mcr_top #(.TICKS_PER_MS(1)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_spi_cs(cs), .i_spi_sclk(sclk),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe), .i_hall_u(hall), .o_hall_u(hall_o),
        .o_rotor_lockup_fault(fault), .o_comm_count_reset(crst), .o_commutation_count(), .o_commutate_lead(lead),
        .o_auto_advance_enable(adv), .o_auto_gain_enable(agn), .o_sine_drive_enable(sine),
        .o_gate_peak_current(peak), .o_gate_dead(dead), .o_gate_boost(boost), .o_integrator_tick(tick),
        .o_speed_comp_gain(gain), .o_speed_filter_enable(fen), .o_speed_filter_pole_coeff(pole),
        .o_speed_filter_zero_coeff(zero));
    initial forever #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (crst === 1'h1) n_rst <= n_rst + 1;
        if (tick === 1'h1) n_tick <= n_tick + 1;
    end
    task automatic wc(input int k);
        repeat (k) @(posedge i_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Slow sclk: each level held 7 clocks to clear the input filter
    task automatic spi(input logic r, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
        logic [23:0] f;
        f = {r, a, d};
        @(posedge i_clk);
        cs <= 1'h1;
        wc(6);
        for (int i = 0; i < 24; i++) begin
            mosi <= f[23-i];
            wc(7);
            if (i > 7) q[23-i] = miso;
            if (i == 12) oe_seen = oe;
            sclk <= 1'h1;
            wc(7);
            sclk <= 1'h0;
        end
        wc(6);
        cs <= 1'h0;
        wc(8);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] q;
        spi(1'h0, a, d, q);
        chk({15'h0, oe_seen}, 16'h0000);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] q;
        spi(1'h1, a, 16'h0000, q);
        chk({15'h0, oe_seen}, 16'h0001);
        chk(q, e);
    endtask
    task automatic span(ref logic s, output int k);
        k = 0;
        while (s !== 1'h1 && k < 20) begin
            @(negedge i_clk);
            k++;
        end
        k = 0;
        while (s === 1'h1 && k < 1000) begin
            @(negedge i_clk);
            k++;
        end
    endtask
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            wr(7'(4 + i), 16'hFFFF);
            rd(7'(4 + i), WR_MASK[i]);
        end
        chk({9'h000, lead, adv, agn, sine, peak}, 16'h007F);
        wr(7'h04, 16'h0A05);
        chk({9'h000, lead, adv, agn, sine, peak}, 16'h0055);
        wr(7'h05, 16'hABCD);
        chk({4'h0, gain}, 16'h0BCD);
        rd(7'h05, 16'h2BCD);
        wr(7'h06, 16'h0123);
        wr(7'h07, 16'hF456);
        chk({fen, 3'h0, pole}, 16'h8123);
        chk({4'h0, zero}, 16'h0456);
        wr(7'h06, 16'h1123);
        chk({fen, 3'h0, pole | zero}, 16'h0000);
        rd(7'h06, 16'h1123);
        wr(7'h06, 16'h0000);
        chk({fen, 3'h0, pole}, 16'h8000);
        // Unmapped word: write dropped, read zero
        wr(7'h08, 16'hFFFF);
        rd(7'h08, 16'h0000);
        rd(7'h04, 16'h0A05);
        $display("register test done");
    endtask
    task automatic t_pol;
        wr(7'h06, 16'h8000);
        chk({15'h0, hall_o}, 16'h0001);
        hall <= 1'h1;
        wc(8);
        chk({15'h0, hall_o}, 16'h0000);
        wr(7'h06, 16'h0000);
        chk({15'h0, hall_o}, 16'h0001);
        hall <= 1'h0;
        wc(10);
        $display("polarity test done");
    endtask
    task automatic t_gate;
        int dc[8] = '{3, 5, 10, 20, 30, 40, 50, 60};
        int bc[4] = '{40, 200, 400, 600};
        for (int c = 0; c < 8; c++) begin
            wr(7'h04, 16'(c * 8 + (c % 4) * 64));
            hall <= 1'h1;
            span(dead, n);
            chk(16'(n), 16'(dc[c]));
            span(boost, n);
            chk(16'(n), 16'(bc[c % 4]));
            hall <= 1'h0;
            wc(10);
        end
        $display("gate timing test done");
    endtask
    task automatic t_count;
        for (int c = 0; c < 4; c++) begin
            wr(7'h04, 16'(c * 4096));
            b = n_rst;
            repeat (8) begin
                hall <= 1'h1;
                wc(20);
                hall <= 1'h0;
                wc(20);
            end
            wc(10);
            chk(16'(n_rst - b), 16'(8 >> c));
        end
        $display("counter reset test done");
    endtask
    task automatic t_tick;
        for (int c = 0; c < 8; c++) begin
            wr(7'h05, 16'(c * 4096));
            b = n_tick;
            wc(256);
            chk(16'(n_tick - b), 16'(256 >> c));
        end
        $display("integrator test done");
    endtask
    // Margin of 40 covers input sync and edge detect delay
    task automatic t_lock;
        for (int c = 0; c < 4; c++) begin
            wr(7'h04, 16'(c * 16384));
            hall <= 1'h1;
            wc(20);
            hall <= 1'h0;
            wc(LOCK_S[c] * 1000 - 40);
            chk({15'h0, fault}, 16'h0000);
            wc(80);
            chk({15'h0, fault}, 16'h0001);
            hall <= 1'h1;
            wc(8);
            chk({15'h0, fault}, 16'h0000);
            hall <= 1'h0;
            wc(20);
        end
        $display("lockup test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        print_verdict;
    end
    initial begin
        wc(4);
        i_arst_n <= 1'h1;
        wc(8);
        t_regs;
        t_pol;
        t_gate;
        t_count;
        t_tick;
        t_lock;
        print_verdict;
    end
endmodule // motor_commutation_loop_config_regs_tb_top

// *** src/mcr_pin_sync.sv ***
`timescale 1ns/1ps
module mcr_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);
    import mcr_pkg::*;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic [SYNC_STAGES-1:0] stage;
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stage <= '0;
                    o_level[g] <= 1'b0;
                end else begin
                    stage <= {stage[SYNC_STAGES-2:0], i_pin[g]};
                    // Only a value held by the last two stages counts
                    if (stage[1] == stage[2]) begin
                        o_level[g] <= stage[2];
                    end
                end
            end
        end
    endgenerate
endmodule // mcr_pin_sync

// *** src/mcr_pkg.sv ***
package mcr_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int SYNC_STAGES = 3;

    localparam int REG_W = 16;
    localparam int ADDR_W = 7;
    localparam int FRAME_W = 24;
    localparam int NUM_REGS = 4;
    localparam int COEF_W = 12;
    localparam int COUNT_W = 16;

    // Word indices on the serial port
    localparam logic [6:0] ADDR_COMM_DRIVE = 7'h04;
    localparam logic [6:0] ADDR_INTEG_GAIN = 7'h05;
    localparam logic [6:0] ADDR_FILT_POLE = 7'h06;
    localparam logic [6:0] ADDR_FILT_ZERO = 7'h07;

    // Field positions
    localparam int LOCK_SEL_LSB = 14;
    localparam int CNT_RST_LSB = 12;
    localparam int LEAD_BIT = 11;
    localparam int AUTO_ADV_BIT = 10;
    localparam int AUTO_GAIN_BIT = 9;
    localparam int SINE_BIT = 8;
    localparam int BOOST_LSB = 6;
    localparam int DEAD_LSB = 3;
    localparam int PEAK_LSB = 0;
    localparam int INTEGRATOR_CLOCK_SEL_LSB = 12;
    localparam int GAIN_LSB = 0;
    localparam int POL_BIT = 15;
    localparam int BYPASS_BIT = 12;
    localparam int COEF_LSB = 0;

    // Writable bits of each word, reserved bits stay zero
    localparam logic [15:0] WR_MASK [NUM_REGS] = '{16'hFFFF, 16'h7FFF, 16'h9FFF, 16'h0FFF};
    localparam logic [15:0] RST_VAL [NUM_REGS] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // Times as printed
    localparam int LOCK_S [4] = '{1, 3, 5, 10};
    localparam int BOOST_US [4] = '{1, 5, 10, 15};
    localparam int DEAD_NS [8] = '{60, 120, 240, 500, 740, 1000, 1240, 1500};
    localparam int HALL_PER_RST [4] = '{1, 2, 4, 8};

    // Least times round up, never below one cycle
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
endpackage

// *** src/mcr_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Lockup timeout code selects 1,3,5,10 s
// - Counter reset every 1,2,4,8 Hall cycles
// - Lead-lag bit: commutate after or before
// - Boost drive time 1,5,10,15 us
// - Dead time code selects eight gap lengths
// - Integrator clock halves per code step
// - Hall polarity bit inverts Hall sense
// - Bypass bit disables filter, coefficients ignored
// - Pole coefficient sets filter pole
// - Zero coefficient sets filter zero
module mcr_top #(
    parameter int TICKS_PER_MS = mcr_pkg::MS_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_spi_cs,
    input wire logic i_spi_sclk,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    input wire logic i_hall_u,
    output logic o_hall_u,
    output logic o_rotor_lockup_fault,
    output logic o_comm_count_reset,
    output logic [mcr_pkg::COUNT_W-1:0] o_commutation_count,
    output logic o_commutate_lead,
    output logic o_auto_advance_enable,
    output logic o_auto_gain_enable,
    output logic o_sine_drive_enable,
    output logic [2:0] o_gate_peak_current,
    output logic o_gate_dead,
    output logic o_gate_boost,
    output logic o_integrator_tick,
    output logic [mcr_pkg::COEF_W-1:0] o_speed_comp_gain,
    output logic o_speed_filter_enable,
    output logic [mcr_pkg::COEF_W-1:0] o_speed_filter_pole_coeff,
    output logic [mcr_pkg::COEF_W-1:0] o_speed_filter_zero_coeff
);
    import mcr_pkg::*;

    function automatic logic [NUM_REGS-1:0] word_hit(input logic [ADDR_W-1:0] a);
        logic [NUM_REGS-1:0] h;
        h = '0;
        if (a == ADDR_COMM_DRIVE) h[0] = 1'b1;
        else if (a == ADDR_INTEG_GAIN) h[1] = 1'b1;
        else if (a == ADDR_FILT_POLE) h[2] = 1'b1;
        else if (a == ADDR_FILT_ZERO) h[3] = 1'b1;
        return h;
    endfunction

    logic [1:0] rst_pipe;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) rst_pipe <= 2'h0;
        else rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    logic [3:0] pins;
    mcr_pin_sync #(.WIDTH(4)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_pin({i_hall_u, i_spi_mosi, i_spi_sclk, i_spi_cs}),
        .o_level(pins)
    );

    // Serial port: R/W bit, 7 address bits, 16 data bits, MSB first
    logic cs_q, sclk_q;
    logic [4:0] bit_cnt;
    logic [FRAME_W-2:0] shreg;
    logic [REG_W-1:0] tx;
    logic is_read;
    logic [REG_W-1:0] regs [NUM_REGS];
    wire cs = pins[0];
    wire sclk_rise = cs & pins[1] & ~sclk_q;
    wire sclk_fall = cs & ~pins[1] & sclk_q;
    wire [FRAME_W-1:0] frame = {shreg, pins[2]};
    wire hdr_done = sclk_rise && (bit_cnt == 5'd7);
    wire frame_done = sclk_rise && (bit_cnt == 5'd23);
    wire [NUM_REGS-1:0] rd_hit = word_hit(frame[ADDR_W-1:0]);
    // Address sits one below the R/W bit in the full frame
    wire [NUM_REGS-1:0] wr_hit = word_hit(frame[FRAME_W-2:REG_W]);
    wire frame_write = frame_done && !is_read;

    logic [REG_W-1:0] rd_word;
    always_comb begin
        rd_word = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (rd_hit[i]) rd_word = regs[i];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_q <= 1'b0;
            sclk_q <= 1'b0;
            bit_cnt <= 5'h00;
            shreg <= '0;
            is_read <= 1'b0;
        end else begin
            cs_q <= cs;
            sclk_q <= pins[1];
            if (cs && !cs_q) begin
                bit_cnt <= 5'h00;
            end else if (sclk_rise) begin
                shreg <= frame[FRAME_W-2:0];
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == 5'h00) is_read <= pins[2];
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx <= '0;
            o_spi_miso <= 1'b0;
            o_spi_miso_oe <= 1'b0;
        end else begin
            if (hdr_done) tx <= is_read ? rd_word : '0;
            else if (sclk_fall && o_spi_miso_oe) tx <= {tx[REG_W-2:0], 1'b0};
            if (sclk_fall && o_spi_miso_oe) o_spi_miso <= tx[REG_W-1];
            // Drive from bit 8 of a read until cs drops, and for one cycle at cs rise after a read
            o_spi_miso_oe <= cs && is_read && (bit_cnt >= 5'd8);
            if (!cs) o_spi_miso <= 1'b0;
        end
    end

    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r++) begin : g_reg
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) regs[r] <= RST_VAL[r];
                else if (frame_write && wr_hit[r]) regs[r] <= frame[REG_W-1:0] & WR_MASK[r];
            end
        end
    endgenerate

    // Field views
    wire [1:0] lock_sel = regs[0][LOCK_SEL_LSB +: 2];
    wire [1:0] cnt_rst_sel = regs[0][CNT_RST_LSB +: 2];
    wire [1:0] boost_sel = regs[0][BOOST_LSB +: 2];
    wire [2:0] dead_sel = regs[0][DEAD_LSB +: 3];
    wire [2:0] integrator_clock_sel_sel = regs[1][INTEGRATOR_CLOCK_SEL_LSB +: 3];
    wire bypass = regs[2][BYPASS_BIT];

    assign o_commutate_lead = regs[0][LEAD_BIT];
    assign o_auto_advance_enable = regs[0][AUTO_ADV_BIT];
    assign o_auto_gain_enable = regs[0][AUTO_GAIN_BIT];
    assign o_sine_drive_enable = regs[0][SINE_BIT];
    assign o_gate_peak_current = regs[0][PEAK_LSB +: 3];
    assign o_speed_comp_gain = regs[1][GAIN_LSB +: COEF_W];

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_speed_filter_enable <= 1'b0;
            o_speed_filter_pole_coeff <= '0;
            o_speed_filter_zero_coeff <= '0;
        end else begin
            o_speed_filter_enable <= !bypass;
            o_speed_filter_pole_coeff <= bypass ? '0 : regs[2][COEF_LSB +: COEF_W];
            o_speed_filter_zero_coeff <= bypass ? '0 : regs[3][COEF_LSB +: COEF_W];
        end
    end

    // Hall sense invert; toggling it can fake one edge
    wire hall = pins[3] ^ regs[2][POL_BIT];
    logic hall_q;
    wire hall_rise = hall & ~hall_q;
    logic [2:0] hall_cyc;
    wire [3:0] hall_per = 4'(HALL_PER_RST[cnt_rst_sel]);
    wire rst_due = hall_rise && ({1'b0, hall_cyc} + 4'h1 >= hall_per);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            hall_q <= 1'b0;
            o_hall_u <= 1'b0;
            hall_cyc <= 3'h0;
            o_comm_count_reset <= 1'b0;
            o_commutation_count <= '0;
        end else begin
            hall_q <= hall;
            o_hall_u <= hall;
            o_comm_count_reset <= rst_due;
            if (rst_due) begin
                hall_cyc <= 3'h0;
                o_commutation_count <= '0;
            end else begin
                if (hall_rise) hall_cyc <= hall_cyc + 3'h1;
                if (o_commutation_count != '1) o_commutation_count <= o_commutation_count + 16'h0001;
            end
        end
    end

    // lockup timer, restarted by any Hall edge
    logic [31:0] ms_div;
    logic [13:0] ms_cnt;
    wire hall_edge = hall ^ hall_q;
    wire [13:0] lock_ms = 14'(LOCK_S[lock_sel] * 1000);
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_div <= '0;
            ms_cnt <= '0;
            o_rotor_lockup_fault <= 1'b0;
        end else if (hall_edge) begin
            ms_div <= '0;
            ms_cnt <= '0;
            o_rotor_lockup_fault <= 1'b0;
        end else if (ms_cnt >= lock_ms) begin
            o_rotor_lockup_fault <= 1'b1;
        end else if (ms_div == 32'(TICKS_PER_MS - 1)) begin
            ms_div <= '0;
            ms_cnt <= ms_cnt + 14'h0001;
        end else begin
            ms_div <= ms_div + 32'h00000001;
        end
    end

    // Dead gap then boost after each Hall rising edge
    logic [9:0] dead_cnt, boost_cnt;
    wire [9:0] dead_len = 10'(ns_to_cycles(DEAD_NS[dead_sel]));
    wire [9:0] boost_len = 10'(ns_to_cycles(BOOST_US[boost_sel] * 1000));
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            dead_cnt <= '0;
            boost_cnt <= '0;
            o_gate_dead <= 1'b0;
            o_gate_boost <= 1'b0;
        end else begin
            if (hall_rise) begin
                dead_cnt <= dead_len;
                boost_cnt <= '0;
            end else if (dead_cnt != '0) begin
                dead_cnt <= dead_cnt - 10'h001;
                if (dead_cnt == 10'h001) boost_cnt <= boost_len;
            end else if (boost_cnt != '0) begin
                boost_cnt <= boost_cnt - 10'h001;
            end
            o_gate_dead <= hall_rise || (dead_cnt > 10'h001);
            // New Hall rise drops boost at once, never overlaps the gap
            o_gate_boost <= !hall_rise && ((dead_cnt == 10'h001) || (boost_cnt > 10'h001));
        end
    end

    // integrator enable halves per code; scaled from the 40 MHz clock
    logic [6:0] int_div;
    wire [6:0] int_mask = 7'((8'h01 << integrator_clock_sel_sel) - 8'h01);
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_div <= '0;
            o_integrator_tick <= 1'b0;
        end else begin
            int_div <= int_div + 7'h01;
            o_integrator_tick <= ((int_div & int_mask) == int_mask);
        end
    end
endmodule // mcr_top
